// *** rtl/aalu_core.sv ***
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
// Operation
// - Rotate right through carry: carry in at bit 7, bit 0 out to carry.
// - Register operand 0..127; dest 0 writes acc, 1 writes register.
// - literal_minus_acc puts literal minus acc in acc, sets C, DC, Z.
// - After literal_minus_acc C=acc<=lit and DC=acc low<=lit low.
// - reg_minus_acc puts register minus acc in dest, sets C, DC, Z.
// - After reg_minus_acc C=acc<=reg and DC=acc low<=reg low.
// - reg_minus_acc_borrow also subtracts inverted carry, sets C, DC, Z.
// - nibble_exchange swaps register nibbles into dest, no flags.
// - literal_xor_acc puts acc xor literal in acc, changes only Z.
// - reg_xor_acc puts acc xor register in dest, changes only Z.
// - direction_load copies acc to direction reg 5, 6 or 7, no flags.
// - Sleep clears sleep_entered_flag and sets expiry_flag.
// - Sleep zeroes the watchdog count and its prescaler.
// - After sleep the core stays in low-power state, clock halted, until the synchronised wake pin is seen.
module aalu_core
  import aalu_pkg::*;
#(
  parameter int FILE_DEPTH = 128
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register bus
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_write,
  input wire logic bus_read,
  output logic [31:0] bus_rdata,
  // Wake request from outside
  input wire logic wake_pin,
  // Port direction outputs
  output logic [7:0] port_a_direction,
  output logic [7:0] port_b_direction,
  output logic [7:0] port_c_direction,
  // Low-power indication
  output logic clock_halted
);

  logic [7:0] acc;
  logic [7:0] file_mem [FILE_DEPTH];
  aalu_status_type status;
  aalu_state_type state;
  logic [WDT_W-1:0] watchdog_timer;
  logic [PRE_W-1:0] prescaler;
  logic [2:0] wake_sync;

  // Command decode from a write to the command register
  wire cmd_hit = bus_write && (bus_addr == OFF_CMD) && (state == ST_RUN);
  wire aalu_cmd_type cmd = '{
    op: aalu_op_type'(bus_wdata[CMD_OP_LSB +: 4]),
    dest: bus_wdata[CMD_DEST_BIT],
    addr: bus_wdata[CMD_REG_LSB +: ADDR_W],
    lit: bus_wdata[CMD_LIT_LSB +: DATA_W]};
  wire [7:0] fval = file_mem[cmd.addr];
  wire borrow_in = (cmd.op == OP_REG_MINUS_ACC_BORROW) ? ~status.carry
                                                     : 1'b0;
  wire [7:0] minuend = (cmd.op == OP_LITERAL_MINUS_ACC) ? cmd.lit : fval;

  // Subtraction: carry out of 9-bit sum is the no-borrow flag
  wire [8:0] sub_full = {1'b0, minuend} + {1'b0, ~acc}
                        + {8'h00, ~borrow_in};
  wire [4:0] sub_low = {1'b0, minuend[3:0]} + {1'b0, ~acc[3:0]}
                       + {4'h0, ~borrow_in};

  // Result selection
  logic [7:0] result;
  always_comb begin
    case (cmd.op)
      OP_ROTATE_RIGHT_CARRY: result = {status.carry, fval[7:1]};
      OP_LITERAL_MINUS_ACC,
      OP_REG_MINUS_ACC,
      OP_REG_MINUS_ACC_BORROW: result = sub_full[7:0];
      OP_NIBBLE_EXCHANGE: result = {fval[3:0], fval[7:4]};
      OP_LITERAL_XOR_ACC: result = acc ^ cmd.lit;
      OP_REG_XOR_ACC: result = acc ^ fval;
      default: result = acc;
    endcase
  end

  wire is_sub = (cmd.op == OP_LITERAL_MINUS_ACC) ||
                (cmd.op == OP_REG_MINUS_ACC) ||
                (cmd.op == OP_REG_MINUS_ACC_BORROW);
  wire is_xor = (cmd.op == OP_LITERAL_XOR_ACC) ||
                (cmd.op == OP_REG_XOR_ACC);
  wire is_reg_form = (cmd.op == OP_ROTATE_RIGHT_CARRY) ||
                     (cmd.op == OP_REG_MINUS_ACC) ||
                     (cmd.op == OP_REG_MINUS_ACC_BORROW) ||
                     (cmd.op == OP_NIBBLE_EXCHANGE) ||
                     (cmd.op == OP_REG_XOR_ACC);
  wire to_file = cmd_hit && is_reg_form && cmd.dest;
  wire to_acc = cmd_hit && ((is_reg_form && !cmd.dest) ||
                (cmd.op == OP_LITERAL_MINUS_ACC) ||
                (cmd.op == OP_LITERAL_XOR_ACC));
  wire is_sleep = cmd_hit && (cmd.op == OP_SLEEP);
  wire res_zero = (result == ZERO8);
  wire wake_seen = wake_sync[1] && wake_sync[2];
  wire file_wr = bus_write && (bus_addr >= OFF_FILE);
  wire [6:0] file_idx = bus_addr[6:0];

  // Next status value
  aalu_status_type next_status;
  always_comb begin
    next_status = status;
    if (cmd_hit && (cmd.op == OP_ROTATE_RIGHT_CARRY)) begin
      next_status.carry = fval[0];
    end
    if (cmd_hit && is_sub) begin
      next_status.carry = sub_full[8];
      next_status.half_carry_flag = sub_low[4];
      next_status.zero = res_zero;
    end
    if (cmd_hit && is_xor) begin
      next_status.zero = res_zero;
    end
    if (is_sleep) begin
      next_status.sleep_entered_flag = 1'b0;
      next_status.expiry_flag = 1'b1;
      next_status.sleep = 1'b1;
    end else if (state == ST_ASLEEP && wake_seen) begin
      next_status.sleep = 1'b0;
    end
  end

  // Rotate: carry into bit 7, bit 0 out to carry, other flags kept
  property p_rot;
    @(posedge ref_clk) disable iff (reset)
    cmd_hit && cmd.op == OP_ROTATE_RIGHT_CARRY
      |=> status.carry == $past(fval[0]) && $stable(status[5:1]);
  endproperty
  a_rot: assert property (p_rot)
    else $error("rotate carry wrong");
  property p_rot_res;
    @(posedge ref_clk) disable iff (reset)
    cmd_hit && cmd.op == OP_ROTATE_RIGHT_CARRY && !cmd.dest
      |=> acc == {$past(status.carry), $past(fval[7:1])};
  endproperty
  a_rot_res: assert property (p_rot_res)
    else $error("rotate result wrong");
  // Register destination leaves the accumulator alone
  property p_dest;
    @(posedge ref_clk) disable iff (reset)
    cmd_hit && is_reg_form && cmd.dest |=> $stable(acc);
  endproperty
  a_dest: assert property (p_dest)
    else $error("accumulator written for register destination");
  // Literal minus accumulator: result and both no-borrow flags
  property p_lit_res;
    @(posedge ref_clk) disable iff (reset)
    cmd_hit && cmd.op == OP_LITERAL_MINUS_ACC
      |=> acc == 8'($past(cmd.lit) - $past(acc));
  endproperty
  a_lit_res: assert property (p_lit_res)
    else $error("literal difference wrong");
  property p_sub_c;
    @(posedge ref_clk) disable iff (reset)
    cmd_hit && cmd.op == OP_LITERAL_MINUS_ACC
      |=> status.carry == ($past(acc) <= $past(cmd.lit))
      && status.half_carry_flag == ($past(acc[3:0]) <= $past(cmd.lit[3:0]));
  endproperty
  a_sub_c: assert property (p_sub_c)
    else $error("sub carry wrong");
  // Register minus accumulator: result and both no-borrow flags
  property p_reg_res;
    @(posedge ref_clk) disable iff (reset)
    cmd_hit && cmd.op == OP_REG_MINUS_ACC && !cmd.dest
      |=> acc == 8'($past(fval) - $past(acc));
  endproperty
  a_reg_res: assert property (p_reg_res)
    else $error("register difference wrong");
  property p_reg_c;
    @(posedge ref_clk) disable iff (reset)
    cmd_hit && cmd.op == OP_REG_MINUS_ACC
      |=> status.carry == ($past(acc) <= $past(fval))
      && status.half_carry_flag == ($past(acc[3:0]) <= $past(fval[3:0]));
  endproperty
  a_reg_c: assert property (p_reg_c)
    else $error("register borrow flags wrong");
  // Borrow form: the inverted carry is taken off as well
  property p_brw_res;
    @(posedge ref_clk) disable iff (reset)
    cmd_hit && cmd.op == OP_REG_MINUS_ACC_BORROW && !cmd.dest
      |=> acc == 8'($past(fval) - $past(acc) - {7'h00, ~$past(status.carry)});
  endproperty
  a_brw_res: assert property (p_brw_res)
    else $error("borrow difference wrong");
  property p_brw_c;
    @(posedge ref_clk) disable iff (reset)
    cmd_hit && cmd.op == OP_REG_MINUS_ACC_BORROW
      |=> status.carry == ({1'b0, $past(acc)} + {8'h00, ~$past(status.carry)}
      <= {1'b0, $past(fval)})
      && status.half_carry_flag == ({1'b0, $past(acc[3:0])}
      + {4'h0, ~$past(status.carry)} <= {1'b0, $past(fval[3:0])});
  endproperty
  a_brw_c: assert property (p_brw_c)
    else $error("borrow flags wrong");
  // Nibble exchange keeps every arithmetic flag
  property p_swap;
    @(posedge ref_clk) disable iff (reset)
    cmd_hit && cmd.op == OP_NIBBLE_EXCHANGE |=> $stable(status[2:0]);
  endproperty
  a_swap: assert property (p_swap)
    else $error("swap flags");
  // Exclusive OR: only the zero flag may move
  property p_xor_flags;
    @(posedge ref_clk) disable iff (reset)
    cmd_hit && is_xor |=> $stable(status[1:0]) && $stable(status[5:3]);
  endproperty
  a_xor_flags: assert property (p_xor_flags)
    else $error("xor touched other flags");
  property p_xor_res;
    @(posedge ref_clk) disable iff (reset)
    cmd_hit && cmd.op == OP_REG_XOR_ACC && !cmd.dest
      |=> acc == ($past(acc) ^ $past(fval));
  endproperty
  a_xor_res: assert property (p_xor_res)
    else $error("xor result wrong");
  // Zero flag follows a result left in the accumulator
  property p_zero;
    @(posedge ref_clk) disable iff (reset)
    to_acc && (is_sub || is_xor) |=> status.zero == (acc == ZERO8);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");
  c_sub: cover property (@(posedge ref_clk) cmd_hit && is_sub);
  c_xor: cover property (@(posedge ref_clk) cmd_hit && is_xor);

  // Wake pin synchroniser
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wake_sync <= 3'h0;
    end else begin
      wake_sync <= {wake_sync[1:0], wake_pin};
    end
  end

  // Accumulator and status
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      acc <= ZERO8;
      status <= '{default: 1'b0, sleep_entered_flag: 1'b1,
                  expiry_flag: 1'b1};
    end else begin
      status <= next_status;
      if (to_acc) begin
        acc <= result;
      end
    end
  end

  // Data register file, no reset on contents
  always_ff @(posedge ref_clk) begin
    if (to_file) begin
      file_mem[cmd.addr] <= result;
    end else if (file_wr) begin
      file_mem[file_idx] <= bus_wdata[7:0];
    end
  end

  // Direction registers
  wire dir_cmd = cmd_hit && (cmd.op == OP_DIRECTION_LOAD);
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      port_a_direction <= DIR_RESET;
      port_b_direction <= DIR_RESET;
      port_c_direction <= DIR_RESET;
    end else if (dir_cmd) begin
      if (cmd.addr == DIR_SEL_A) port_a_direction <= acc;
      if (cmd.addr == DIR_SEL_B) port_b_direction <= acc;
      if (cmd.addr == DIR_SEL_C) port_c_direction <= acc;
    end
  end

  // Direction load to port B copies the accumulator and leaves the flags alone
  property p_dir;
    @(posedge ref_clk) disable iff (reset)
    dir_cmd && cmd.addr == DIR_SEL_B
      |=> port_b_direction == $past(acc) && $stable(status);
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction load wrong");

  // Watchdog count, prescaler and sleep state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      watchdog_timer <= '0;
      prescaler <= '0;
      state <= ST_RUN;
      clock_halted <= 1'b0;
    end else if (is_sleep) begin
      watchdog_timer <= '0;
      prescaler <= '0;
      state <= ST_ASLEEP;
      clock_halted <= 1'b1;
    end else begin
      case (state)
        ST_RUN: begin
          prescaler <= prescaler + 1'b1;
          if (prescaler == '1) watchdog_timer <= watchdog_timer + 1'b1;
        end
        ST_ASLEEP: begin
          if (wake_seen) begin
            state <= ST_RUN;
            clock_halted <= 1'b0;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // Sleep side effects and the halted state
  property p_sleep;
    @(posedge ref_clk) disable iff (reset)
    is_sleep |=> !status.sleep_entered_flag && status.expiry_flag
      && watchdog_timer == '0 && clock_halted;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep effects");
  property p_wdt;
    @(posedge ref_clk) disable iff (reset)
    is_sleep |=> watchdog_timer == '0 && prescaler == '0;
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog not cleared by sleep");
  property p_asleep;
    @(posedge ref_clk) disable iff (reset)
    state == ST_ASLEEP && !wake_seen
      |=> clock_halted && $stable(acc) && $stable(watchdog_timer);
  endproperty
  a_asleep: assert property (p_asleep)
    else $error("activity while asleep");
  c_sleep: cover property (@(posedge ref_clk) is_sleep);
  c_wake: cover property (@(posedge ref_clk) state == ST_ASLEEP && wake_seen);

  // Read mux
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (bus_addr >= OFF_FILE) next_rdata[7:0] = file_mem[file_idx];
    else case (bus_addr)
      OFF_ACC: next_rdata[7:0] = acc;
      OFF_STATUS: next_rdata[5:0] = status;
      OFF_DIR_A: next_rdata[7:0] = port_a_direction;
      OFF_DIR_B: next_rdata[7:0] = port_b_direction;
      OFF_DIR_C: next_rdata[7:0] = port_c_direction;
      OFF_WDT: next_rdata[7:0] = watchdog_timer;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) bus_rdata <= 32'h0000_0000;
    else bus_rdata <= bus_read ? next_rdata : 32'h0000_0000;
  end

endmodule

// *** rtl/aalu_pkg.sv ***
package aalu_pkg;

  // Data and addressing widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int NIB_W = 4;

  // Register bus offsets (byte addresses, one word each; file registers one byte each from OFF_FILE)
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_DIR_A = 8'h0C;
  localparam logic [7:0] OFF_DIR_B = 8'h10;
  localparam logic [7:0] OFF_DIR_C = 8'h14;
  localparam logic [7:0] OFF_WDT = 8'h18;
  localparam logic [7:0] OFF_FILE = 8'h80;

  // Command word fields: [3:0] opcode, [4] dest, [11:5] reg, [19:12] lit
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DEST_BIT = 4;
  localparam int CMD_REG_LSB = 5;
  localparam int CMD_LIT_LSB = 12;

  // Status bit positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PD_N = 3;
  localparam int ST_TO_N = 4;
  localparam int ST_SLEEP = 5;

  // Direction load operand codes
  localparam logic [6:0] DIR_SEL_A = 7'h05;
  localparam logic [6:0] DIR_SEL_B = 7'h06;
  localparam logic [6:0] DIR_SEL_C = 7'h07;

  // Reset values
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] ZERO8 = 8'h00;

  // Watchdog widths
  localparam int WDT_W = 8;
  localparam int PRE_W = 8;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_ROTATE_RIGHT_CARRY = 4'h1,
    OP_LITERAL_MINUS_ACC = 4'h2,
    OP_REG_MINUS_ACC = 4'h3,
    OP_REG_MINUS_ACC_BORROW = 4'h4,
    OP_NIBBLE_EXCHANGE = 4'h5,
    OP_LITERAL_XOR_ACC = 4'h6,
    OP_REG_XOR_ACC = 4'h7,
    OP_DIRECTION_LOAD = 4'h8,
    OP_SLEEP = 4'h9
  } aalu_op_type;

  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_ASLEEP = 1'b1
  } aalu_state_type;

  // Decoded command
  typedef struct packed {
    aalu_op_type op;
    logic dest;
    logic [6:0] addr;
    logic [7:0] lit;
  } aalu_cmd_type;

  // Status flags
  typedef struct packed {
    logic sleep;
    logic expiry_flag;
    logic sleep_entered_flag;
    logic zero;
    logic half_carry_flag;
    logic carry;
  } aalu_status_type;

endpackage

// *** tb/aalu_tb.sv ***
`timescale 1ns/1ps
module testbench
  import aalu_pkg::*;
;
  // Stimulus and observed signals
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic [7:0] bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0;
  logic bus_write = 1'h0;
  logic bus_read = 1'h0;
  logic wake_pin = 1'h0;
  logic [31:0] bus_rdata;
  wire [7:0] dir [3];
  logic clock_halted;
  logic [31:0] d, st;
  int mismatches = 0;
  int tests_run = 0;

  aalu_core aalu_core_inst (.ref_clk(ref_clk), .reset(reset),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
    .bus_read(bus_read), .bus_rdata(bus_rdata), .wake_pin(wake_pin),
    .port_a_direction(dir[0]), .port_b_direction(dir[1]),
    .port_c_direction(dir[2]), .clock_halted(clock_halted));

  // 40 MHz clock
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_write <= 1'h1;
    @(posedge ref_clk);
    bus_write <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_read <= 1'h1;
    @(posedge ref_clk);
    bus_read <= 1'h0;
    #1 v = bus_rdata;
  endtask

  task automatic cmd(input aalu_op_type op, input logic dst,
                     input logic [6:0] r, input logic [7:0] k);
    bus_wr(OFF_CMD, {12'h000, k, r, dst, op});
  endtask

  task automatic wr_file(input logic [6:0] r, input logic [7:0] v);
    bus_wr(OFF_FILE + {1'h0, r}, {24'h0, v});
  endtask

  task automatic set_acc(input logic [7:0] v);
    bus_rd(OFF_ACC, d);
    cmd(OP_LITERAL_XOR_ACC, 1'h0, 7'h00, d[7:0] ^ v);
  endtask

  // Zero minus acc leaves carry set only when acc is zero
  task automatic set_carry(input logic c);
    set_acc(c ? 8'h00 : 8'h01);
    cmd(OP_LITERAL_MINUS_ACC, 1'h0, 7'h00, 8'h00);
  endtask

  task automatic run_sub(input aalu_op_type op, input logic dst,
                         input logic [7:0] f, a, input logic cin);
    logic [8:0] r;
    logic [4:0] n;
    logic b;
    set_carry(cin);
    set_acc(a);
    wr_file(7'h7F, f);
    cmd(op, dst, 7'h7F, f);
    b = (op == OP_REG_MINUS_ACC_BORROW) ? ~cin : 1'h0;
    r = {1'h0, f} - {1'h0, a} - {8'h00, b};
    n = {1'h0, f[3:0]} - {1'h0, a[3:0]} - {4'h0, b};
    bus_rd(OFF_STATUS, st);
    chk("flags", {29'h0, r[7:0] == 8'h00, ~n[4], ~r[8]}, st & 32'h7);
    bus_rd(dst ? 8'hFF : OFF_ACC, d);
    chk("difference", {24'h0, r[7:0]}, d);
    bus_rd(dst ? OFF_ACC : 8'hFF, d);
    chk("other place", {24'h0, dst ? a : f}, d);
  endtask

  task automatic t_reset();
    bus_rd(OFF_STATUS, st);
    chk("status", 32'h18, st);
    bus_rd(8'h40, d);
    chk("unmapped", 32'h0, d);
    for (int i = 0; i < 3; i++)
      chk("direction", {24'h0, DIR_RESET}, {24'h0, dir[i]});
  endtask

  task automatic t_sub();
    run_sub(OP_LITERAL_MINUS_ACC, 1'h0, 8'h05, 8'h05, 1'h1);
    run_sub(OP_LITERAL_MINUS_ACC, 1'h0, 8'h10, 8'h01, 1'h1);
    run_sub(OP_LITERAL_MINUS_ACC, 1'h0, 8'h00, 8'hFF, 1'h1);
    run_sub(OP_REG_MINUS_ACC, 1'h0, 8'h80, 8'h7F, 1'h1);
    run_sub(OP_REG_MINUS_ACC, 1'h1, 8'h7F, 8'h80, 1'h0);
    run_sub(OP_REG_MINUS_ACC_BORROW, 1'h0, 8'h05, 8'h04, 1'h0);
    run_sub(OP_REG_MINUS_ACC_BORROW, 1'h1, 8'h00, 8'h00, 1'h0);
    run_sub(OP_REG_MINUS_ACC_BORROW, 1'h1, 8'h12, 8'h02, 1'h1);
  endtask

  // Z and DC stay set while only the carry moves
  task automatic t_rotate();
    set_carry(1'h1);
    wr_file(7'h00, 8'h02);
    cmd(OP_ROTATE_RIGHT_CARRY, 1'h1, 7'h00, 8'h00);
    bus_rd(OFF_FILE, d);
    chk("rotated reg", 32'h81, d);
    bus_rd(OFF_STATUS, st);
    chk("rotate flags", 32'h6, st & 32'h7);
    cmd(OP_ROTATE_RIGHT_CARRY, 1'h0, 7'h00, 8'h00);
    bus_rd(OFF_ACC, d);
    chk("rotated acc", 32'h40, d);
    bus_rd(OFF_STATUS, st);
    chk("rotate carry", 32'h7, st & 32'h7);
  endtask

  task automatic t_swap_xor();
    logic [31:0] s0;
    wr_file(7'h05, 8'h3C);
    set_acc(8'h5A);
    bus_rd(OFF_STATUS, s0);
    cmd(OP_NIBBLE_EXCHANGE, 1'h0, 7'h05, 8'h00);
    cmd(OP_NIBBLE_EXCHANGE, 1'h1, 7'h05, 8'h00);
    bus_rd(OFF_ACC, d);
    chk("swap acc", 32'hC3, d);
    bus_rd(OFF_FILE + 8'h05, d);
    chk("swap reg", 32'hC3, d);
    bus_rd(OFF_STATUS, st);
    chk("swap flags", s0, st);
    cmd(OP_LITERAL_XOR_ACC, 1'h0, 7'h00, 8'hC3);
    bus_rd(OFF_STATUS, st);
    chk("xor zero", s0 | 32'h4, st);
    wr_file(7'h09, 8'hF0);
    cmd(OP_REG_XOR_ACC, 1'h1, 7'h09, 8'h00);
    bus_rd(OFF_FILE + 8'h09, d);
    chk("xor reg", 32'hF0, d);
    bus_rd(OFF_STATUS, st);
    chk("xor flags", s0 & ~32'h4, st);
    cmd(OP_REG_XOR_ACC, 1'h0, 7'h09, 8'h00);
    cmd(OP_REG_XOR_ACC, 1'h1, 7'h09, 8'h00);
    bus_rd(OFF_FILE + 8'h09, d);
    chk("xor back", 32'h0, d);
    bus_rd(OFF_ACC, d);
    chk("xor acc", 32'hF0, d);
  endtask

  // Status read around each load; the later reads let the outputs settle
  task automatic t_dir();
    for (int i = 0; i < 3; i++) begin
      set_acc(8'hA1 + 8'(i * 17));
      bus_rd(OFF_STATUS, st);
      cmd(OP_DIRECTION_LOAD, 1'h0, DIR_SEL_A + 7'(i), 8'h00);
      bus_rd(OFF_STATUS, d);
      chk("dir flags", st, d);
    end
    for (int i = 0; i < 3; i++)
      chk("direction", 32'hA1 + 32'(i * 17), {24'h0, dir[i]});
  endtask

  task automatic t_sleep();
    logic [31:0] a0;
    int k;
    bus_rd(OFF_ACC, a0);
    cmd(OP_SLEEP, 1'h0, 7'h00, 8'h00);
    bus_rd(OFF_STATUS, st);
    chk("sleep status", 32'h30, st & 32'h38);
    bus_rd(OFF_WDT, d);
    chk("watchdog", 32'h0, d);
    chk("halted", 32'h1, {31'h0, clock_halted});
    cmd(OP_LITERAL_XOR_ACC, 1'h0, 7'h00, 8'hFF);
    wake_pin <= 1'h1;
    for (k = 0; k < 20 && clock_halted !== 1'h0; k++)
      @(posedge ref_clk);
    wake_pin <= 1'h0;
    chk("woken", 32'h0, {31'h0, clock_halted});
    bus_rd(OFF_ACC, d);
    chk("acc asleep", a0, d);
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'h0;
    t_reset();
    t_sub();
    t_rotate();
    t_swap_xor();
    t_dir();
    t_sleep();
    report_and_stop();
  end

  // Hang guard
  initial begin
    #(25 * 5000);
    mismatches++;
    report_and_stop();
  end
endmodule
